// file: rtl/dmse_pkg.sv
package dmse_pkg;
    localparam int MEM_BYTES = 128;
    localparam int ADDR_W = 7;
    localparam int PAGE_BYTES = 8;
    localparam int PAGE_W = 3;
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam int CLK_HZ = 10_000_000;
    localparam int SCL_MAX_HZ = 400_000;
    localparam int SCL_MIN_CYC = (CLK_HZ + SCL_MAX_HZ - 1) / SCL_MAX_HZ;
    localparam int PROG_TIME_US = 10;
    localparam int PROG_CYC = (PROG_TIME_US * (CLK_HZ / 1_000_000) > 0) ? PROG_TIME_US * (CLK_HZ / 1_000_000) : 1;
    localparam logic [7:0] ERASED = 8'hff;
    typedef enum logic [2:0] {
        DMSE_IDLE = 3'b000,
        DMSE_DEVA = 3'b001,
        DMSE_WORD = 3'b011,
        DMSE_WDAT = 3'b010,
        DMSE_RDAT = 3'b110,
        DMSE_RACK = 3'b111,
        DMSE_SKIP = 3'b101
    } dmse_state_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic transmit_only_clock;
    } dmse_pins_t;
endpackage

// file: rtl/dmse_sync.sv
`timescale 1ns/1ns
`default_nettype none
module dmse_sync #(
    parameter int W = 3
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] s1_q;
    initial begin
        if (W < 1) $error("dmse_sync width");
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q <= '1;
            q_out <= '1;
        end else begin
            s1_q <= d_in;
            q_out <= s1_q;
        end
    end
endmodule
`default_nettype wire

// file: rtl/dmse_top.sv
`timescale 1ns/1ns
`default_nettype none
module dmse_top #(
    parameter int PROG_CYCLES = dmse_pkg::PROG_CYC
) (
    // Clock and reset
    input wire logic CORE_CLK_IN,
    input wire logic RESETN_IN,
    // Two-wire bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    // Transmit-only clock
    input wire logic TRANSMIT_ONLY_CLOCK_IN,
    // Status
    output logic I2C_MODE_OUT,
    output logic BUSY_OUT
);
    localparam int AW = dmse_pkg::ADDR_W;
    initial begin
        if (PROG_CYCLES < 1) $error("PROG_CYCLES must be positive");
        if ((1 << AW) != dmse_pkg::MEM_BYTES) $error("address width mismatch");
        // Edge finding costs three core cycles, so a bus clock period needs several of them
        if (dmse_pkg::SCL_MIN_CYC < 8) $error("core clock too slow for the bus clock");
    end

    // ----------------------------------------
    // Input synchronisation and edges
    // ----------------------------------------
    dmse_pkg::dmse_pins_t raw, syn;
    assign raw = '{scl: SCL_IN, sda: SDA_IN, transmit_only_clock: TRANSMIT_ONLY_CLOCK_IN};
    dmse_sync #(.W(3)) u_sync (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESETN_IN),
        .d_in(raw),
        .q_out(syn)
    );
    logic scl_q, sda_q, transmit_only_clock_q;
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            transmit_only_clock_q <= 1'b1;
        end else begin
            scl_q <= syn.scl;
            sda_q <= syn.sda;
            transmit_only_clock_q <= syn.transmit_only_clock;
        end
    end
    wire scl_rise = syn.scl && !scl_q;
    wire scl_fall = !syn.scl && scl_q;
    wire transmit_only_clock_rise = syn.transmit_only_clock && !transmit_only_clock_q;
    wire start_c = scl_q && syn.scl && sda_q && !syn.sda;
    wire stop_c = scl_q && syn.scl && !sda_q && syn.sda;

    // ----------------------------------------
    // Memory and mode
    // ----------------------------------------
    // Cells start erased, so transmit-only mode never shifts out unknown bits
    logic [7:0] mem [dmse_pkg::MEM_BYTES] = '{default: dmse_pkg::ERASED};
    logic i2c_mode_q;
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            i2c_mode_q <= 1'b0;
        end else if (scl_fall) begin
            i2c_mode_q <= 1'b1;
        end
    end
    assign I2C_MODE_OUT = i2c_mode_q;

    function automatic logic [AW-1:0] page_next(input logic [AW-1:0] a);
        page_next = {a[AW-1:dmse_pkg::PAGE_W], a[dmse_pkg::PAGE_W-1:0] + 3'h1};
    endfunction

    // ----------------------------------------
    // Bus protocol
    // ----------------------------------------
    dmse_pkg::dmse_state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q;
    logic [AW-1:0] addr_q, tx_addr_q;
    logic [2:0] tx_bit_q;
    logic ack_q, rd_q, rack_q;
    logic [7:0] wbuf_q [dmse_pkg::PAGE_BYTES];
    logic [dmse_pkg::PAGE_W:0] wcnt_q;
    logic [AW-1:0] wbase_q;
    logic prog_req;
    logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_q;
    wire busy = prog_cnt_q != '0;
    assign BUSY_OUT = busy;

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            st_q <= dmse_pkg::DMSE_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            addr_q <= '0;
            ack_q <= 1'b0;
            rd_q <= 1'b0;
            rack_q <= 1'b0;
            wcnt_q <= '0;
            wbase_q <= '0;
        end else if (!i2c_mode_q) begin
            st_q <= dmse_pkg::DMSE_IDLE;
        end else if (start_c) begin
            st_q <= dmse_pkg::DMSE_DEVA;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            wcnt_q <= '0;
        end else if (stop_c) begin
            st_q <= dmse_pkg::DMSE_IDLE;
            ack_q <= 1'b0;
        end else if (scl_rise) begin
            if (bit_q < 4'h8) begin
                sh_q <= {sh_q[6:0], syn.sda};
                bit_q <= bit_q + 4'h1;
            end else if (st_q == dmse_pkg::DMSE_RACK) begin
                rack_q <= !syn.sda;
            end
        end else if (scl_fall) begin
            if (st_q == dmse_pkg::DMSE_RACK) begin
                // The host's acknowledge decides whether another byte follows
                bit_q <= 4'h0;
                st_q <= rack_q ? dmse_pkg::DMSE_RDAT : dmse_pkg::DMSE_SKIP;
                addr_q <= addr_q + 7'h1;
            end else if (bit_q == 4'h8 && !ack_q) begin
                unique case (st_q)
                    dmse_pkg::DMSE_DEVA: begin
                        ack_q <= sh_q[7:1] == dmse_pkg::DEV_ADDR && !busy;
                        rd_q <= sh_q[0];
                    end
                    dmse_pkg::DMSE_WORD: begin
                        ack_q <= 1'b1;
                        addr_q <= sh_q[AW-1:0];
                        wbase_q <= sh_q[AW-1:0];
                    end
                    dmse_pkg::DMSE_WDAT: begin
                        ack_q <= 1'b1;
                        if (wcnt_q < 4'(dmse_pkg::PAGE_BYTES)) wcnt_q <= wcnt_q + 4'h1;
                        addr_q <= page_next(addr_q);
                    end
                    dmse_pkg::DMSE_RDAT: begin
                        st_q <= dmse_pkg::DMSE_RACK;
                    end
                    default: begin
                        st_q <= dmse_pkg::DMSE_SKIP;
                    end
                endcase
                if (st_q == dmse_pkg::DMSE_DEVA && (sh_q[7:1] != dmse_pkg::DEV_ADDR || busy)) begin
                    st_q <= dmse_pkg::DMSE_SKIP;
                end
            end else if (bit_q == 4'h8) begin
                ack_q <= 1'b0;
                bit_q <= 4'h0;
                unique case (st_q)
                    dmse_pkg::DMSE_DEVA: st_q <= rd_q ? dmse_pkg::DMSE_RDAT : dmse_pkg::DMSE_WORD;
                    dmse_pkg::DMSE_WORD: st_q <= dmse_pkg::DMSE_WDAT;
                    default: st_q <= st_q;
                endcase
            end
        end
    end

    // Page bytes are staged and only committed after the stop, as real cells would
    always_ff @(posedge CORE_CLK_IN) begin
        if (i2c_mode_q && scl_fall && bit_q == 4'h8 && !ack_q && st_q == dmse_pkg::DMSE_WDAT) begin
            wbuf_q[addr_q[dmse_pkg::PAGE_W-1:0]] <= sh_q;
        end
    end

    assign prog_req = i2c_mode_q && stop_c && st_q == dmse_pkg::DMSE_WDAT && wcnt_q != '0;

    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            prog_cnt_q <= '0;
        end else if (prog_req) begin
            prog_cnt_q <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES);
        end else if (busy) begin
            prog_cnt_q <= prog_cnt_q - 1'b1;
        end
    end

    // Marks of the staged page, cleared at the next start condition
    logic [dmse_pkg::PAGE_BYTES-1:0] dirty_q;
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dirty_q <= '0;
        end else if (start_c && i2c_mode_q) begin
            dirty_q <= '0;
        end else if (i2c_mode_q && scl_fall && bit_q == 4'h8 && !ack_q && st_q == dmse_pkg::DMSE_WDAT) begin
            dirty_q[addr_q[dmse_pkg::PAGE_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (prog_req) begin
            for (int i = 0; i < dmse_pkg::PAGE_BYTES; i++) begin
                if (dirty_q[i]) mem[{wbase_q[AW-1:dmse_pkg::PAGE_W], 3'(i)}] <= wbuf_q[i];
            end
        end
    end

    // ----------------------------------------
    // Data output
    // ----------------------------------------
    logic [7:0] rd_byte;
    assign rd_byte = mem[addr_q];
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tx_addr_q <= '0;
            tx_bit_q <= 3'h0;
        end else if (!i2c_mode_q && transmit_only_clock_rise) begin
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == 3'h7) tx_addr_q <= tx_addr_q + 7'h1;
        end
    end

    logic sda_oe_q;
    always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sda_oe_q <= 1'b0;
        end else if (!i2c_mode_q) begin
            sda_oe_q <= !mem[tx_addr_q][3'h7 - tx_bit_q];
        end else if (scl_fall || start_c || stop_c) begin
            sda_oe_q <= 1'b0;
        end else if (!syn.scl) begin
            if (bit_q == 4'h8 && ack_q) sda_oe_q <= 1'b1;
            else if (st_q == dmse_pkg::DMSE_RDAT && bit_q < 4'h8) sda_oe_q <= !rd_byte[3'(4'h7 - bit_q)];
        end
    end
    // Open drain: the pin is only ever pulled low
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = sda_oe_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_mode_sticky: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        i2c_mode_q |=> i2c_mode_q) else $error("left I2C mode");
    a_mode_entry: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        scl_fall |=> i2c_mode_q) else $error("no I2C mode after SCL fall");
    a_mode_cause: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        !i2c_mode_q && !scl_fall |=> !i2c_mode_q) else $error("mode changed without SCL fall");
    a_tx_advance: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        !i2c_mode_q && !scl_fall && transmit_only_clock_rise |=> tx_bit_q == $past(tx_bit_q) + 3'h1) else $error("tx bit stuck");
    a_prog_start: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        prog_req |=> busy) else $error("programming did not start");
    a_busy_nack: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        busy && st_q == dmse_pkg::DMSE_DEVA && bit_q == 4'h8 && scl_fall && !ack_q |=> !ack_q)
        else $error("acked while busy");
    a_page_wrap: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        st_q == dmse_pkg::DMSE_WDAT && !start_c |=> addr_q[AW-1:3] == wbase_q[AW-1:3]) else $error("left page");
    a_page_count: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        wcnt_q <= 4'(dmse_pkg::PAGE_BYTES)) else $error("page count overflow");
    a_read_advance: assert property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        i2c_mode_q && st_q == dmse_pkg::DMSE_RACK && scl_fall |=> addr_q == $past(addr_q) + 7'h1)
        else $error("read address did not advance");
    c_mode_switch: cover property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) $rose(i2c_mode_q));
    c_prog: cover property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN) $fell(busy));
    c_seq_read: cover property (@(posedge CORE_CLK_IN) disable iff (!RESETN_IN)
        st_q == dmse_pkg::DMSE_RACK ##1 st_q == dmse_pkg::DMSE_RDAT);
endmodule
`default_nettype wire

// file: verif/dmse_host.sv
`timescale 1ns/1ns
`default_nettype none
module dmse_host (
    // Core clock
    input wire logic clk_in,
    // Two-wire bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    // ----------------------------------------
    // Bus master, open drain on data
    // ----------------------------------------
    // Half period in core cycles; 13 keeps the bus clock under 400 kHz, larger values act as a slow host
    int hp = 13;
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    task automatic wt();
        repeat (hp) @(posedge clk_in);
    endtask
    // Data moves a few cycles after the clock fall so the device never sees both pins move together
    task automatic bit_io(input logic b, output logic r);
        repeat (4) @(posedge clk_in);
        sda_pull_out <= !b;
        wt();
        scl_out <= 1'b1;
        wt();
        r = sda_in;
        scl_out <= 1'b0;
    endtask
    task automatic start();
        sda_pull_out <= 1'b0;
        wt();
        scl_out <= 1'b1;
        wt();
        sda_pull_out <= 1'b1;
        wt();
        scl_out <= 1'b0;
    endtask
    task automatic stop();
        repeat (4) @(posedge clk_in);
        sda_pull_out <= 1'b1;
        wt();
        scl_out <= 1'b1;
        wt();
        sda_pull_out <= 1'b0;
        wt();
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(!ack, r);
    endtask
endmodule
`default_nettype wire

// file: verif/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tclk = 1'b0;
    logic tx_run = 1'b0;
    logic scl, sda_pull, sda_o, sda_oe, i2c_mode, busy, sda, ack;
    logic [7:0] d;
    logic [7:0] mem [128];
    int error_cnt = 0;
    int n_checks = 0;
    int seed = 32'h2cae4ba8;
    int cyc = 0;
    always #50 clk = ~clk;
    // Transmit clock: 800 ns, odd phase, still outside frames
    initial begin
        #23;
        forever #400 tclk = tx_run ? ~tclk : 1'b0;
    end
    // Pull-up on the data wire
    assign sda = !sda_pull && (sda_oe ? sda_o : 1'b1);
    dmse_host h (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_pull_out(sda_pull));
    dmse_top #(.PROG_CYCLES(1000)) dut (.CORE_CLK_IN(clk), .RESETN_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda),
        .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .TRANSMIT_ONLY_CLOCK_IN(tclk), .I2C_MODE_OUT(i2c_mode),
        .BUSY_OUT(busy));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("wrong value at %0t: timeout", $time);
            conclude();
        end
    end
    // Current-address read used as a busy poll, so an empty write never starts programming
    task automatic poll(output logic a);
        h.start();
        h.put_byte(8'ha1, a);
        if (a) h.get_byte(1'b0, d);
        h.stop();
    endtask
    task automatic wr(input logic [6:0] a, input int n);
        logic [7:0] v;
        h.start();
        h.put_byte(8'ha0, ack);
        chk(ack, 1, "device ack");
        h.put_byte({1'b0, a}, ack);
        for (int i = 0; i < n; i++) begin
            v = $random(seed);
            h.put_byte(v, ack);
            chk(ack, 1, "data ack");
            mem[(a & 7'h78) | ((a + i) & 7)] = v;
        end
        h.stop();
        repeat (10) @(posedge clk);
        chk(busy, 1, "busy after stop");
        poll(ack);
        chk(ack, 0, "poll while busy");
        for (int k = 0; k < 20 && !ack; k++) poll(ack);
        chk(ack, 1, "poll after programming");
        $display("write at %h of %0d bytes done", a, n);
    endtask
    task automatic rd(input logic [6:0] a, input int n);
        h.start();
        h.put_byte(8'ha0, ack);
        h.put_byte({1'b0, a}, ack);
        h.start();
        h.put_byte(8'ha1, ack);
        chk(ack, 1, "read ack");
        for (int i = 0; i < n; i++) begin
            h.get_byte(i < n - 1, d);
            chk(d, mem[(a + i) & 127], "read data");
        end
        h.stop();
        $display("read at %h of %0d bytes done", a, n);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk(i2c_mode, 0, "mode at power-up");
        // The first bus clock fall only switches modes, so this empty frame is lost
        h.start();
        h.stop();
        chk(i2c_mode, 1, "mode after first frame");
        wr(7'h05, 10);
        chk(i2c_mode, 1, "mode after bus clock fall");
        h.hp = 30;
        wr(7'h08, 1);
        h.hp = 13;
        wr(7'h7f, 1);
        rd(7'h02, 6);
        h.start();
        h.put_byte(8'ha1, ack);
        h.get_byte(1'b0, d);
        h.stop();
        chk(d, mem[8], "current address read");
        rd(7'h7f, 1);
        tx_run = 1'b1;
        repeat (4) @(posedge tclk);
        tx_run = 1'b0;
        chk(i2c_mode, 1, "mode kept");
        $display("bus mode test done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        chk(i2c_mode, 0, "mode after power cycle");
        tx_run = 1'b1;
        for (int b = 0; b < 16; b++) begin
            @(posedge tclk);
            chk(sda, mem[b / 8][7 - b % 8], "transmit bit");
        end
        tx_run = 1'b0;
        $display("transmit-only test done");
        conclude();
    end
endmodule
`default_nettype wire
